/* File: rtl/rfs_consts.svh */
// Register offsets, reset values, rail indices and timing figures of the rail fault supervisor
`ifndef RFS_CONSTS_SVH
`define RFS_CONSTS_SVH

// Register offsets
`define RFS_ADDR_GOOD_A      8'h40
`define RFS_ADDR_GOOD_B      8'h41
`define RFS_ADDR_RECORD_A    8'h42
`define RFS_ADDR_RECORD_B    8'h43
`define RFS_ADDR_MASK_A      8'h44
`define RFS_ADDR_MASK_B      8'h45
`define RFS_ADDR_SHUTDOWN    8'h49
`define RFS_ADDR_DISCH_A     8'h4A
`define RFS_ADDR_SW_EN_A     8'h4E
`define RFS_ADDR_SW_EN_B     8'h4F
`define RFS_ADDR_LP_EN       8'h57
`define RFS_ADDR_VOUT_ACT    8'h50
`define RFS_ADDR_VOUT_LOW    8'h58

// Field positions
`define RFS_SHUTDOWN_FORCE_BIT 0
`define RFS_SHUTDOWN_STATE_BIT 7

// Reset values
`define RFS_MASK_RESET       8'h00
`define RFS_DISCH_RESET      4'hF
`define RFS_VOUT_RESET       8'h80
`define RFS_LP_EN_RESET      5'h1F

// Rail and regulator indices
`define RFS_RAIL_DEEP_SLEEP_3V3 14
`define RFS_RAIL_ALWAYS_ON_5V   15
`define RFS_REG_CONVERTER       1
`define RFS_REG_MEMORY          3

// Timing
`define RFS_CLK_MHZ          10
`define RFS_QUAL_US          30
`define RFS_ENABLE_BLANK_MS  10
`define RFS_WAKE_BLANK_US    100
`define RFS_SHUTDOWN_US      1

`endif

/* File: rtl/rfs_pkg.sv */
// Types of the rail fault supervisor
package rfs_pkg;
	typedef enum logic {rfs_run, rfs_halt} rfs_state_t;
endpackage

/* File: rtl/rfs_supervisor.sv */
// Rail fault supervisor: rail monitoring, emergency shutdown, discharge, low power and RTC path
// Notes on behaviour
// R1: Each enabled rail has a readable good bit, one inside window, zero outside.
// R2: Any unmasked rail fault shuts all rails down by default.
// R3: Faulting rail is recorded in battery-backed fault source registers.
// R4: A set mask bit stops that rail's fault from causing shutdown.
// R5: Faults on a rail are ignored for 10 ms after it is enabled.
// R6: Fault detection suppressed 100 us after system power good rises.
// R7: Deep-sleep 3.3 V and always-on 5 V rails are never monitored; here only their fault trip is blocked, their good bits still read.
// R8: Current limit alone never shuts down; only a qualified droop does.
// R9: Fault needs out-of-window output lasting at least 30 us.
// R10: Shutdown starts only on lockouts, rail fault, overtemp, request pin, forced write.
// R11: Every rail is disabled within 1 us of shutdown.
// R12: Internal 3.3 V, 5 V and reference stay on while inputs exceed lockout.
// R13: Discharge connects only when configured and regulator disabled.
// R14: Rail voltage codes come from writable control registers.
// R15: Integrated converter uses low-power voltage while idle sleep is low.
// R16: Termination pin steers memory regulator; low-power pin steers the other four.
// R17: Good monitoring is unaffected by low-power entry and exit.
// R18: Small ramp above 11 V, large ramp again 1.1 V lower.
// R19: RTC domain fed from higher of coin cell and main input via 3.1 V.
// R20: Below 5.4 V main input, RTC regulator bypassed, coin cell feeds domain.
// R21: Shutdown held until button falling edge, adapter rising, or input lockout.
// R22: Low-power pin low selects low power, high selects active mode.
// R23: Each rail has its own blanking timer restarted on every enable.
`timescale 1ns/1ns
`include "rfs_consts.svh"
module rfs_supervisor
#(
	parameter int NRAIL        = 16,
	parameter int NREG         = 5,
	parameter int BLANK_CYCLES = `RFS_ENABLE_BLANK_MS * 1000 * `RFS_CLK_MHZ
)
(
	// Clock and resets
	input  wire logic                clk,
	input  wire logic                reset_n,
	input  wire logic                rtc_reset_n,
	// Register port
	input  wire logic [7:0]          reg_addr,
	input  wire logic [7:0]          reg_wdata,
	input  wire logic                reg_we,
	input  wire logic                reg_re,
	output logic      [7:0]          reg_rdata,
	// Rail comparators and enable pins
	input  wire logic [NRAIL-1:0]    rail_in_window,
	input  wire logic [NRAIL-1:0]    rail_enable_pin,
	// Platform pins
	input  wire logic                shutdown_request_n,
	input  wire logic                platform_idle_sleep_n,
	input  wire logic                memory_termination_control,
	input  wire logic                low_power_request_n,
	input  wire logic                system_power_good,
	input  wire logic                power_button_input,
	input  wire logic                adapter_present,
	// Supply comparators
	input  wire logic                main_input_lockout,
	input  wire logic                ldo_input_lockout,
	input  wire logic                die_over_temp,
	input  wire logic                vin_above_11v,
	input  wire logic                vin_below_9v9,
	input  wire logic                vin_above_5v4,
	input  wire logic                coin_above_main,
	// Rail controls
	output logic      [NRAIL-1:0]    rail_on,
	output logic      [NRAIL-1:0]    rail_discharge,
	output logic      [NREG*8-1:0]   regulator_vsel,
	output logic      [NREG-1:0]     regulator_low_power,
	// Internal supplies and status
	output logic                     ldo3_enable,
	output logic                     ldo5_enable,
	output logic                     reference_enable,
	output logic                     small_ramp,
	output logic                     rtc_ldo_enable,
	output logic                     rtc_from_coin,
	output logic                     shutdown_active
);
	localparam int NMISC = 14;
	localparam int NSYNC = NMISC + 2 * NRAIL;
	localparam int QUAL_CYCLES = `RFS_QUAL_US * `RFS_CLK_MHZ;
	localparam int WAKE_CYCLES = `RFS_WAKE_BLANK_US * `RFS_CLK_MHZ;
	localparam int BW = $clog2(BLANK_CYCLES + 1);
	localparam int QW = $clog2(QUAL_CYCLES + 1);
	localparam int WW = $clog2(WAKE_CYCLES + 1);
	localparam logic [NSYNC-1:0] SYNC_INIT = NSYNC'(14'h002F);
	localparam logic [NRAIL-1:0] EXCLUDED = (NRAIL'(1) << `RFS_RAIL_DEEP_SLEEP_3V3)
		| (NRAIL'(1) << `RFS_RAIL_ALWAYS_ON_5V);

	// Input synchronisers, three stages, change taken when stages two and three agree
	logic [NSYNC-1:0] s1_r, s2_r, s3_r, filt_r, filt_d_r;
	wire  [NSYNC-1:0] raw = {rail_enable_pin, rail_in_window, coin_above_main, vin_above_5v4,
		vin_below_9v9, vin_above_11v, die_over_temp, ldo_input_lockout, main_input_lockout,
		adapter_present, power_button_input, system_power_good, low_power_request_n,
		memory_termination_control, platform_idle_sleep_n, shutdown_request_n};
	wire  [NSYNC-1:0] filt_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & filt_r);

	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
		begin
			s1_r     <= SYNC_INIT;
			s2_r     <= SYNC_INIT;
			s3_r     <= SYNC_INIT;
			filt_r   <= SYNC_INIT;
			filt_d_r <= SYNC_INIT;
		end
		else
		begin
			s1_r     <= raw;
			s2_r     <= s1_r;
			s3_r     <= s2_r;
			filt_r   <= filt_nxt;
			filt_d_r <= filt_r;
		end

	wire             sdreq_n_f  = filt_r[0];
	wire             idle_n_f   = filt_r[1];
	wire             memterm_f  = filt_r[2];
	wire             lpreq_n_f  = filt_r[3];
	wire             spg_rise   = filt_r[4] & ~filt_d_r[4];
	wire             btn_fall   = ~filt_r[5] & filt_d_r[5];
	wire             adp_rise   = filt_r[6] & ~filt_d_r[6];
	wire             mlock_f    = filt_r[7];
	wire             mlock_rise = filt_r[7] & ~filt_d_r[7];
	wire             llock_f    = filt_r[8];
	wire             otemp_f    = filt_r[9];
	wire             above11_f  = filt_r[10];
	wire             below99_f  = filt_r[11];
	wire             above54_f  = filt_r[12];
	wire             coinhi_f   = filt_r[13];
	wire [NRAIL-1:0] win_f      = filt_r[NMISC +: NRAIL];
	wire [NRAIL-1:0] en_pin_f   = filt_r[NMISC + NRAIL +: NRAIL];

	// Software registers
	logic [NRAIL-1:0]  mask_r, sw_en_r, disch_cfg_r, record_r;
	logic [7:0]        sdctl_r;
	logic [NREG-1:0]   lp_en_r;
	logic [7:0]        vout_act_r [NREG];
	logic [7:0]        vout_low_r [NREG];
	rfs_pkg::rfs_state_t state_r, state_nxt;

	wire wr_mask_a  = reg_we & (reg_addr == `RFS_ADDR_MASK_A);
	wire wr_mask_b  = reg_we & (reg_addr == `RFS_ADDR_MASK_B);
	wire wr_swen_a  = reg_we & (reg_addr == `RFS_ADDR_SW_EN_A);
	wire wr_swen_b  = reg_we & (reg_addr == `RFS_ADDR_SW_EN_B);
	wire wr_rec_a   = reg_we & (reg_addr == `RFS_ADDR_RECORD_A);
	wire wr_rec_b   = reg_we & (reg_addr == `RFS_ADDR_RECORD_B);
	wire wr_sdctl   = reg_we & (reg_addr == `RFS_ADDR_SHUTDOWN);
	wire wr_lp_en   = reg_we & (reg_addr == `RFS_ADDR_LP_EN);
	wire force_wr   = wr_sdctl & reg_wdata[`RFS_SHUTDOWN_FORCE_BIT];
	wire [NRAIL-1:0] rec_clr = {wr_rec_b ? reg_wdata : 8'h00, wr_rec_a ? reg_wdata : 8'h00};

	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
		begin
			mask_r  <= {2{`RFS_MASK_RESET}};
			sw_en_r <= '0;
			sdctl_r <= 8'h00;
			lp_en_r <= `RFS_LP_EN_RESET;
		end
		else
		begin
			if (wr_mask_a) mask_r[7:0]   <= reg_wdata;
			if (wr_mask_b) mask_r[15:8]  <= reg_wdata;
			if (wr_swen_a) sw_en_r[7:0]  <= reg_wdata;
			if (wr_swen_b) sw_en_r[15:8] <= reg_wdata;
			if (wr_sdctl)  sdctl_r       <= reg_wdata;
			if (wr_lp_en)  lp_en_r       <= reg_wdata[NREG-1:0];
		end

	// Discharge configuration, four rails per register
	genvar g;
	generate
		for (g = 0; g < NRAIL / 4; g++)
		begin : g_disch
			wire wr_d = reg_we & (reg_addr == `RFS_ADDR_DISCH_A + 8'(g));
			always_ff @(posedge clk or negedge reset_n)
				if (!reset_n)
					disch_cfg_r[g*4 +: 4] <= `RFS_DISCH_RESET;
				else if (wr_d)
					disch_cfg_r[g*4 +: 4] <= reg_wdata[3:0];
		end
	endgenerate

	// Per-regulator voltage codes and low-power selection
	logic [NREG-1:0] lp_req;
	generate
		for (g = 0; g < NREG; g++)
		begin : g_vreg
			wire wr_act = reg_we & (reg_addr == `RFS_ADDR_VOUT_ACT + 8'(g));
			wire wr_low = reg_we & (reg_addr == `RFS_ADDR_VOUT_LOW + 8'(g));
			if (g == `RFS_REG_MEMORY)
				assign lp_req[g] = ~memterm_f; // R16
			else if (g == `RFS_REG_CONVERTER)
				assign lp_req[g] = ~idle_n_f | ~lpreq_n_f; // R15
			else
				assign lp_req[g] = ~lpreq_n_f; // R22
			wire lp_sel = lp_req[g] & lp_en_r[g]; // R16
			always_ff @(posedge clk or negedge reset_n)
				if (!reset_n)
				begin
					vout_act_r[g]            <= `RFS_VOUT_RESET;
					vout_low_r[g]            <= `RFS_VOUT_RESET;
					regulator_vsel[g*8 +: 8] <= `RFS_VOUT_RESET;
					regulator_low_power[g]   <= 1'b0;
				end
				else
				begin
					if (wr_act) vout_act_r[g] <= reg_wdata; // R14
					if (wr_low) vout_low_r[g] <= reg_wdata;
					regulator_vsel[g*8 +: 8] <= lp_sel ? vout_low_r[g] : vout_act_r[g]; // R14
					regulator_low_power[g]   <= lp_sel;
				end
		end
	endgenerate

	// Wake blanking after system power good rises
	logic [WW-1:0] wake_cnt_r;
	wire           wake_blank = wake_cnt_r != '0;
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
			wake_cnt_r <= '0;
		else if (spg_rise)
			wake_cnt_r <= WW'(WAKE_CYCLES); // R6
		else if (wake_blank)
			wake_cnt_r <= wake_cnt_r - WW'(1);

	// Per-rail blanking, qualification and good status
	logic [NRAIL-1:0] qual, good;
	generate
		for (g = 0; g < NRAIL; g++)
		begin : g_rail
			logic [BW-1:0] blank_r;
			logic [QW-1:0] bad_r;
			wire           on  = rail_on[g];
			wire           out = on & ~win_f[g];
			always_ff @(posedge clk or negedge reset_n)
				if (!reset_n)
				begin
					blank_r <= BW'(BLANK_CYCLES);
					bad_r   <= '0;
				end
				else
				begin
					if (!on)
						blank_r <= BW'(BLANK_CYCLES); // R23
					else if (blank_r != '0)
						blank_r <= blank_r - BW'(1); // R5
					if (!out)
						bad_r <= '0;
					else if (bad_r != QW'(QUAL_CYCLES))
						bad_r <= bad_r + QW'(1); // R9
				end
			// Low-power state deliberately not a term here
			assign good[g] = on & win_f[g]; // R1 R17
			assign qual[g] = (bad_r == QW'(QUAL_CYCLES)) & (blank_r == '0) & ~wake_blank
				& ~EXCLUDED[g]; // R5 R6 R7 R8 R9
		end
	endgenerate

	// Fault source record, kept on the battery-backed reset; set wins over clear
	wire [NRAIL-1:0] fault_trip = qual & ~mask_r; // R4
	always_ff @(posedge clk or negedge rtc_reset_n)
		if (!rtc_reset_n)
			record_r <= '0;
		else
			record_r <= (record_r & ~rec_clr) | fault_trip; // R3

	// Emergency shutdown sequencing
	wire trip_hold = (|fault_trip) | llock_f | otemp_f | ~sdreq_n_f | force_wr; // R2 R10
	wire trip      = trip_hold | mlock_f; // R10
	wire exit_evt  = btn_fall | adp_rise | mlock_rise; // R21
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			rfs_pkg::rfs_run:
				if (trip)
					state_nxt = rfs_pkg::rfs_halt;
			rfs_pkg::rfs_halt:
				if (exit_evt && !trip_hold)
					state_nxt = rfs_pkg::rfs_run; // R21
			default:
				state_nxt = rfs_pkg::rfs_halt;
		endcase
	end

	wire             halt_nxt = state_nxt == rfs_pkg::rfs_halt;
	wire [NRAIL-1:0] en_req   = en_pin_f | sw_en_r;
	wire [NRAIL-1:0] on_nxt   = halt_nxt | mlock_f ? '0 : en_req; // R11
	wire [7:0] rd_mux =
		reg_addr == `RFS_ADDR_GOOD_A   ? good[7:0] :
		reg_addr == `RFS_ADDR_GOOD_B   ? good[15:8] :
		reg_addr == `RFS_ADDR_RECORD_A ? record_r[7:0] :
		reg_addr == `RFS_ADDR_RECORD_B ? record_r[15:8] :
		reg_addr == `RFS_ADDR_MASK_A   ? mask_r[7:0] :
		reg_addr == `RFS_ADDR_MASK_B   ? mask_r[15:8] :
		reg_addr == `RFS_ADDR_SW_EN_A  ? sw_en_r[7:0] :
		reg_addr == `RFS_ADDR_SW_EN_B  ? sw_en_r[15:8] :
		reg_addr == `RFS_ADDR_SHUTDOWN ? {shutdown_active, sdctl_r[6:0]} :
		reg_addr == `RFS_ADDR_LP_EN    ? 8'(lp_en_r) :
		reg_addr == `RFS_ADDR_DISCH_A        ? {4'h0, disch_cfg_r[3:0]} :
		reg_addr == `RFS_ADDR_DISCH_A + 8'h1 ? {4'h0, disch_cfg_r[7:4]} :
		reg_addr == `RFS_ADDR_DISCH_A + 8'h2 ? {4'h0, disch_cfg_r[11:8]} :
		reg_addr == `RFS_ADDR_DISCH_A + 8'h3 ? {4'h0, disch_cfg_r[15:12]} : 8'h00;

	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
		begin
			state_r          <= rfs_pkg::rfs_run;
			rail_on          <= '0;
			rail_discharge   <= '0;
			shutdown_active  <= 1'b0;
			reg_rdata        <= 8'h00;
			ldo3_enable      <= 1'b0;
			ldo5_enable      <= 1'b0;
			reference_enable <= 1'b0;
			small_ramp       <= 1'b0;
			rtc_ldo_enable   <= 1'b0;
			rtc_from_coin    <= 1'b1;
		end
		else
		begin
			state_r          <= state_nxt;
			rail_on          <= on_nxt; // R11
			rail_discharge   <= disch_cfg_r & ~on_nxt; // R13
			shutdown_active  <= halt_nxt;
			if (reg_re)
				reg_rdata <= rd_mux;
			ldo3_enable      <= ~llock_f; // R12
			ldo5_enable      <= ~mlock_f; // R12
			reference_enable <= ~mlock_f; // R12
			if (above11_f)
				small_ramp <= 1'b1; // R18
			else if (below99_f)
				small_ramp <= 1'b0; // R18
			rtc_ldo_enable   <= above54_f & ~mlock_f; // R19 R20
			rtc_from_coin    <= ~above54_f | mlock_f | coinhi_f; // R19 R20
		end
endmodule

/* File: verification/rfs_supervisor_properties.sv */
// Port-level checks of the rail fault supervisor
`timescale 1ns/1ns
`include "rfs_consts.svh"
module rfs_supervisor_properties
#(
	parameter int NRAIL = 16,
	parameter int NREG  = 5
)
(
	// Clock and reset
	input wire logic             clk,
	input wire logic             reset_n,
	// Register port
	input wire logic [7:0]       reg_addr,
	input wire logic [7:0]       reg_wdata,
	input wire logic             reg_we,
	// Pins and comparators
	input wire logic [NRAIL-1:0] rail_in_window,
	input wire logic             shutdown_request_n,
	input wire logic             platform_idle_sleep_n,
	input wire logic             memory_termination_control,
	input wire logic             main_input_lockout,
	input wire logic             ldo_input_lockout,
	input wire logic             die_over_temp,
	input wire logic             vin_above_11v,
	input wire logic             vin_below_9v9,
	input wire logic             vin_above_5v4,
	input wire logic             coin_above_main,
	// Outputs
	input wire logic [NRAIL-1:0] rail_on,
	input wire logic [NRAIL-1:0] rail_discharge,
	input wire logic [NREG-1:0]  regulator_low_power,
	input wire logic             ldo3_enable,
	input wire logic             ldo5_enable,
	input wire logic             reference_enable,
	input wire logic             small_ramp,
	input wire logic             rtc_ldo_enable,
	input wire logic             rtc_from_coin,
	input wire logic             shutdown_active
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic       src;
	logic [7:0] age_r;
	// Any legal trip cause; excluded rails 14 and 15 are left out on purpose
	assign src = !shutdown_request_n | main_input_lockout | ldo_input_lockout | die_over_temp
		| (|(rail_on[13:0] & ~rail_in_window[13:0]))
		| (reg_we & (reg_addr == `RFS_ADDR_SHUTDOWN) & reg_wdata[0]);
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			age_r <= 8'hFF;
		else if (src)
			age_r <= 8'h00;
		else if (age_r != 8'hFF)
			age_r <= age_r + 8'h01;
	end
	property p_src; $rose(shutdown_active) |-> age_r < 8'h08; endproperty
	a_src: assert property (p_src) else $error("shutdown without cause");
	property p_off; shutdown_active |-> rail_on == '0; endproperty
	a_off: assert property (p_off) else $error("rail on in shutdown");
	property p_disch; (rail_on & rail_discharge) == '0; endproperty
	a_disch: assert property (p_disch) else $error("discharge on enabled rail");
	property p_supply; (shutdown_active && !ldo_input_lockout && !main_input_lockout)[*8]
		|-> ldo3_enable && ldo5_enable && reference_enable; endproperty
	a_supply: assert property (p_supply) else $error("internal supply dropped");
	property p_small; vin_above_11v[*8] |-> small_ramp; endproperty
	a_small: assert property (p_small) else $error("large ramp at high input");
	property p_large; vin_below_9v9[*8] |-> !small_ramp; endproperty
	a_large: assert property (p_large) else $error("small ramp at low input");
	property p_coin; (!vin_above_5v4)[*8] |-> rtc_from_coin && !rtc_ldo_enable; endproperty
	a_coin: assert property (p_coin) else $error("clock domain not on coin");
	property p_ldo; (vin_above_5v4 && !main_input_lockout && !coin_above_main)[*8]
		|-> rtc_ldo_enable && !rtc_from_coin; endproperty
	a_ldo: assert property (p_ldo) else $error("clock domain not on regulator");
	property p_conv; (!platform_idle_sleep_n)[*8] |-> regulator_low_power[1]; endproperty
	a_conv: assert property (p_conv) else $error("converter not low power");
	property p_mem; (!memory_termination_control)[*8] |-> regulator_low_power[3]; endproperty
	a_mem: assert property (p_mem) else $error("memory regulator not low power");
	c_sd: cover property ($rose(shutdown_active));
	c_ramp: cover property ($rose(small_ramp));
	c_lp: cover property ($rose(regulator_low_power[3]));
endmodule

/* File: verification/rfs_rail_model.sv */
// Behavioural rails answering the supervisor's enables
`timescale 1ns/1ns
module rfs_rail_model
(
	// Clock
	input  wire logic        clk,
	// Enables and injected droop
	input  wire logic [15:0] rail_on,
	input  wire logic [15:0] droop,
	// Window comparators
	output logic      [15:0] rail_in_window
);
	logic [15:0] up1_r, up2_r;
	// Short soft start; an off or drooping rail is out of window
	always_ff @(posedge clk)
	begin
		up1_r <= rail_on;
		up2_r <= up1_r & rail_on;
	end
	assign rail_in_window = up2_r & rail_on & ~droop;
endmodule

/* File: verification/rfs_supervisor_tb.sv */
// Self-checking bench of the rail fault supervisor
`timescale 1ns/1ns
`include "rfs_consts.svh"
module rfs_supervisor_tb;
	// Blanking kept longer than the 300-cycle qualification so both are visible
	localparam int BLANK = 400;
	localparam logic [24:0] TAB [10] = '{{1'b0, `RFS_ADDR_RECORD_A, 16'h0000},
		{1'b0, `RFS_ADDR_MASK_A, 16'h0000}, {1'b0, `RFS_ADDR_DISCH_A, 16'h000F},
		{1'b1, `RFS_ADDR_VOUT_LOW, 16'h6600}, {1'b0, `RFS_ADDR_LP_EN, 16'h001F},
		{1'b0, 8'h60, 16'h0000}, {1'b1, 8'h60, 16'h5A00}, {1'b1, `RFS_ADDR_GOOD_A, 16'hFF00},
		{1'b1, `RFS_ADDR_MASK_B, 16'hA5A5}, {1'b1, `RFS_ADDR_VOUT_ACT, 16'h7C00}};
	localparam logic [7:0] LPT [4] = '{{3'b011, 5'h17}, {3'b101, 5'h08}, {3'b110, 5'h02},
		{3'b111, 5'h00}};
	logic        clk, reset_n, rtc_reset_n, reg_we, reg_re;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
	logic [15:0] rail_in_window, rail_enable_pin, droop, rail_on, rail_discharge;
	logic        shutdown_request_n, platform_idle_sleep_n, memory_termination_control;
	logic        low_power_request_n, system_power_good, power_button_input, adapter_present;
	logic        main_input_lockout, ldo_input_lockout, die_over_temp, vin_above_11v;
	logic        vin_below_9v9, vin_above_5v4, coin_above_main;
	logic [39:0] regulator_vsel;
	logic [4:0]  regulator_low_power;
	logic        ldo3_enable, ldo5_enable, reference_enable, small_ramp;
	logic        rtc_ldo_enable, rtc_from_coin, shutdown_active;
	int          n_mismatch, check_count, n;
	rfs_supervisor #(.BLANK_CYCLES(BLANK)) dut_u (.*);
	rfs_rail_model mdl_u (.*);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
	begin
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask
	task automatic finish_test();
	begin
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
	begin
		{reg_addr, reg_wdata, reg_we} = {a, v, 1'b1};
		@(negedge clk);
		reg_we = 1'b0;
	end
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
	begin
		{reg_addr, reg_re} = {a, 1'b1};
		@(negedge clk);
		reg_re = 1'b0;
		@(negedge clk);
		v = reg_rdata;
	end
	endtask
	// Bounded wait for the shutdown flag; n returns the cycles taken
	task automatic wsd(input logic e, input int lim);
	begin
		n = 0;
		while (shutdown_active !== e && n < lim)
		begin
			@(negedge clk);
			n++;
		end
		if (shutdown_active !== e)
		begin
			n_mismatch++;
			finish_test();
		end
	end
	endtask
	task automatic exit_sd();
	begin
		power_button_input = 1'b0;
		wsd(1'b0, 20);
		power_button_input = 1'b1;
		repeat (6) @(negedge clk);
	end
	endtask
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial
	begin
		{n_mismatch, check_count, reset_n, rtc_reset_n, reg_we, reg_re} = '0;
		{reg_addr, reg_wdata, rail_enable_pin, droop} = '0;
		{shutdown_request_n, platform_idle_sleep_n, memory_termination_control} = 3'b111;
		{low_power_request_n, power_button_input, vin_below_9v9, vin_above_5v4} = 4'hF;
		{system_power_good, adapter_present, main_input_lockout, ldo_input_lockout} = 4'h0;
		{die_over_temp, vin_above_11v, coin_above_main} = 3'b000;
		repeat (6) @(negedge clk);
		chk({rtc_from_coin, shutdown_active, rail_on[5:0]}, 8'h80);
		chk(regulator_vsel[7:0], 8'h80);
		{reset_n, rtc_reset_n} = 2'b11;
		repeat (6) @(negedge clk);
		for (int i = 0; i < 10; i++)
		begin
			if (TAB[i][24])
				wr(TAB[i][23:16], TAB[i][15:8]);
			rd(TAB[i][23:16], d);
			chk(d, TAB[i][7:0]);
		end
		chk({regulator_vsel[7:0], rail_discharge[3:0]}, 16'h07CF);
		wr(`RFS_ADDR_SW_EN_A, 8'h01);
		repeat (BLANK + 10) @(negedge clk);
		chk({rail_on[0], rail_discharge[0]}, 2'b10);
		rd(`RFS_ADDR_GOOD_A, d);
		chk(d, 8'h01);
		wr(`RFS_ADDR_MASK_A, 8'h01);
		droop[0] = 1'b1;
		repeat (400) @(negedge clk);
		rd(`RFS_ADDR_GOOD_A, d);
		chk({shutdown_active, d}, 9'h000);
		wr(`RFS_ADDR_MASK_A, 8'h00);
		wsd(1'b1, 320);
		chk(rail_on, 16'h0000);
		repeat (10) @(negedge clk);
		droop[0] = 1'b0;
		wr(`RFS_ADDR_SW_EN_A, 8'h00);
		exit_sd();
		reset_n = 1'b0;
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
		rd(`RFS_ADDR_RECORD_A, d);
		chk(d, 8'h01);
		rtc_reset_n = 1'b0;
		@(negedge clk);
		rtc_reset_n = 1'b1;
		rd(`RFS_ADDR_RECORD_A, d);
		chk(d, 8'h00);
		{droop[1], rail_enable_pin[1]} = 2'b11;
		wsd(1'b1, 500);
		chk({n >= BLANK, n <= BLANK + 20}, 2'b11);
		{droop[1], rail_enable_pin[1]} = 2'b00;
		exit_sd();
		rail_enable_pin = 16'hC004;
		repeat (BLANK + 10) @(negedge clk);
		droop = 16'hC000;
		repeat (400) @(negedge clk);
		chk(shutdown_active, 1'b0);
		// Droop shorter than the qualification time
		droop[2] = 1'b1;
		repeat (250) @(negedge clk);
		droop[2] = 1'b0;
		repeat (10) @(negedge clk);
		chk(shutdown_active, 1'b0);
		system_power_good = 1'b1;
		repeat (3) @(negedge clk);
		droop[2] = 1'b1;
		repeat (900) @(negedge clk);
		chk(shutdown_active, 1'b0);
		wsd(1'b1, 600);
		{rail_enable_pin, droop, system_power_good} = '0;
		exit_sd();
		rd(`RFS_ADDR_RECORD_A, d);
		chk(d, 8'h06);
		wr(`RFS_ADDR_RECORD_A, 8'h02);
		rd(`RFS_ADDR_RECORD_A, d);
		chk(d, 8'h04);
		rd(`RFS_ADDR_RECORD_B, d);
		chk(d, 8'h00);
		for (int k = 0; k < 4; k++)
		begin
			case (k)
				0: shutdown_request_n = 1'b0;
				1: die_over_temp = 1'b1;
				2: ldo_input_lockout = 1'b1;
				default: wr(`RFS_ADDR_SHUTDOWN, 8'h01);
			endcase
			wsd(1'b1, 20);
			{shutdown_request_n, die_over_temp, ldo_input_lockout} = 3'b100;
			rd(`RFS_ADDR_SHUTDOWN, d);
			chk(d[7], 1'b1);
			{power_button_input, adapter_present} = {2{k[0]}};
			wsd(1'b0, 20);
			{power_button_input, adapter_present} = 2'b10;
			repeat (6) @(negedge clk);
		end
		main_input_lockout = 1'b1;
		wsd(1'b1, 20);
		chk({ldo3_enable, ldo5_enable, reference_enable}, 3'b100);
		chk({rtc_from_coin, rtc_ldo_enable}, 2'b10);
		main_input_lockout = 1'b0;
		exit_sd();
		wr(`RFS_ADDR_VOUT_LOW, 8'h66);
		for (int i = 0; i < 4; i++)
		begin
			{low_power_request_n, memory_termination_control, platform_idle_sleep_n} = LPT[i][7:5];
			repeat (10) @(negedge clk);
			chk(regulator_low_power, LPT[i][4:0]);
			chk(regulator_vsel[7:0], LPT[i][7] ? 8'h80 : 8'h66);
		end
		{vin_below_9v9, vin_above_11v} = 2'b01;
		repeat (10) @(negedge clk);
		vin_above_11v = 1'b0;
		repeat (10) @(negedge clk);
		chk(small_ramp, 1'b1);
		vin_below_9v9 = 1'b1;
		repeat (10) @(negedge clk);
		chk(small_ramp, 1'b0);
		vin_above_5v4 = 1'b0;
		repeat (10) @(negedge clk);
		chk({rtc_from_coin, rtc_ldo_enable}, 2'b10);
		vin_above_5v4 = 1'b1;
		repeat (10) @(negedge clk);
		chk({rtc_from_coin, rtc_ldo_enable}, 2'b01);
		coin_above_main = 1'b1;
		repeat (10) @(negedge clk);
		chk({rtc_from_coin, rtc_ldo_enable}, 2'b11);
		finish_test();
	end
endmodule
bind rfs_supervisor rfs_supervisor_properties #(.NRAIL(NRAIL), .NREG(NREG)) chk_u (.*);
